// *** hdl/shc_defs.svh ***
// constants for the sleep and handler control block
// assumes inclusion by bare name from hdl files
`ifndef SHC_DEFS_SVH
`define SHC_DEFS_SVH
`define SHC_OFF_SLEEP       12'h000
`define SHC_OFF_HANDLER     12'h004
`define SHC_OFF_IRQ_STATUS  12'h008
`define SHC_OFF_IRQ_MASK    12'h00C
`define SHC_SLP_ON_EXIT     1
`define SHC_SLP_DEEP        2
`define SHC_SLP_ANY_PEND    4
`define SHC_SLP_MASK        32'h0000_0016
`define SHC_HS_MEM_ACT      0
`define SHC_HS_BUS_ACT      1
`define SHC_HS_USG_ACT      3
`define SHC_HS_SVC_ACT      7
`define SHC_HS_MON_ACT      8
`define SHC_HS_PSV_ACT      10
`define SHC_HS_TICK_ACT     11
`define SHC_HS_USG_PEND     12
`define SHC_HS_MEM_PEND     13
`define SHC_HS_BUS_PEND     14
`define SHC_HS_SVC_PEND     15
`define SHC_HS_MEM_EN       16
`define SHC_HS_BUS_EN       17
`define SHC_HS_USG_EN       18
`define SHC_IRQ_WAKE        0
`define SHC_IRQ_DOZE        1
`define SHC_IRQ_BITS        2
`define SHC_RESET_WORD      32'h0000_0000
`endif

// *** hdl/shc_event_latch.sv ***
// event register: set by an event, consumed by a wait-for-event
// assumes all inputs on mclk; set wins over consume
`timescale 1ns/100ps
module shc_event_latch (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic event_in,
  input  wire logic consume,
  output logic      event_reg
);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      event_reg <= 1'b0;
    end else if (ce) begin
      if (event_in) begin
        event_reg <= 1'b1;
      end else if (consume) begin
        event_reg <= 1'b0;
      end
    end
  end
endmodule : shc_event_latch

// *** hdl/shc_pkg.sv ***
// types for the sleep and handler control block
// assumes the defs header supplies all numeric constants
package shc_pkg;
  typedef struct packed {
    logic usage;
    logic bus;
    logic memmanage;
    logic supervisor;
  } shc_pend_type;
  typedef struct packed {
    logic system_tick;
    logic pendable_service;
    logic debug_monitor;
    logic supervisor_call;
    logic usage_fault;
    logic bus_fault;
    logic memmanage_fault;
  } shc_act_type;
  typedef enum logic [1:0] {
    SHC_RUN   = 2'b00,
    SHC_SLEEP = 2'b01,
    SHC_DEEP  = 2'b10
  } shc_power_type;
endpackage : shc_pkg

// *** hdl/shc_sync.sv ***
// two-flop synchroniser for a single asynchronous level
// assumes mclk domain, synchronous active-low reset
`timescale 1ns/100ps
module shc_sync (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (ce) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : shc_sync

// *** hdl/shc_top.sv ***
// sleep control and system handler control/state registers on apb
// assumes core signals on mclk, external event pin asynchronous
// What this block does
// - with wake-on-any-pending clear only enabled interrupts or events wake the core.
// - with wake-on-any-pending set enabled events and all interrupts wake the core.
// - a newly pending event or interrupt raises the wake event from wait-for-event.
// - an event while not waiting is latched so the next wait-for-event does not sleep.
// - a send-event instruction or external event input also wakes the core.
// - bit 2 picks sleep (0) or deep sleep (1) as low-power mode.
// - bit 1 set makes the core sleep on return from handler to thread mode.
// - bits 18..16 enable usage, bus and memmanage faults.
// - bits 15..12 read the pending state of supervisor call and the three faults.
// - software writes to pending bits set or clear those pending states.
// - active state of each system handler is shown at its bit position.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "shc_defs.svh"
module shc_top #(
  parameter int NUM_IRQ = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_IRQ-1:0]   irq_pending,
  input  wire logic [NUM_IRQ-1:0]   irq_enabled,
  input  wire logic                 event_enabled_pulse,
  input  wire logic                 send_event_instr,
  input  wire logic                 ext_event_pin,
  input  wire logic                 wait_for_event_instr,
  input  wire logic                 wait_for_irq_instr,
  input  wire logic                 handler_to_thread,
  input  wire shc_pkg::shc_pend_type pend_set,
  input  wire shc_pkg::shc_pend_type pend_clr,
  input  wire shc_pkg::shc_act_type  active_in,
  output shc_pkg::shc_pend_type     pend_out,
  output logic [2:0]                fault_enable,
  output logic                      wake_event,
  output logic                      wfe_complete,
  output shc_pkg::shc_power_type    power_state,
  output logic                      deep_sleep,
  output logic                      irq
);
  logic                  on_exit_reg;
  logic                  deep_reg;
  logic                  any_pend_reg;
  logic [2:0]            enable_reg;
  shc_pkg::shc_pend_type pend_reg;
  shc_pkg::shc_act_type  act_reg;
  logic [NUM_IRQ-1:0]    irq_prev_reg;
  logic [1:0]            istat_reg;
  logic [1:0]            imask_reg;
  shc_pkg::shc_power_type power_reg;
  logic                  ext_sync;
  logic                  ext_prev_reg;
  logic                  wfe_waiting_reg;
  logic                  event_reg;
  logic                  wr_en;
  logic                  rd_en;
  logic [NUM_IRQ-1:0]    irq_new;
  logic [NUM_IRQ-1:0]    irq_wake_src;
  logic                  any_wake;
  logic                  doze_req;
  logic                  addr_ok;
  logic [31:0]           rd_word;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && ce;
  assign rd_en   = psel && penable && !pwrite && ce;
  assign addr_ok = hit(paddr, `SHC_OFF_SLEEP) || hit(paddr, `SHC_OFF_HANDLER)
                || hit(paddr, `SHC_OFF_IRQ_STATUS) || hit(paddr, `SHC_OFF_IRQ_MASK);
  assign pslverr = psel && penable && !addr_ok;

  shc_sync u_ext_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .ce       (ce),
    .async_in (ext_event_pin),
    .sync_out (ext_sync)
  );

  // sleep control register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      on_exit_reg  <= 1'b0;
      deep_reg     <= 1'b0;
      any_pend_reg <= 1'b0;
    end else if (wr_en && hit(paddr, `SHC_OFF_SLEEP)) begin
      on_exit_reg  <= pwdata[`SHC_SLP_ON_EXIT];
      deep_reg     <= pwdata[`SHC_SLP_DEEP];
      any_pend_reg <= pwdata[`SHC_SLP_ANY_PEND];
    end
  end

  // fault enables
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      enable_reg <= 3'h0;
    end else if (wr_en && hit(paddr, `SHC_OFF_HANDLER)) begin
      enable_reg <= pwdata[`SHC_HS_USG_EN:`SHC_HS_MEM_EN];
    end
  end
  assign fault_enable = enable_reg;

  // pending state: software write, then core set wins over clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_reg <= '0;
    end else if (ce) begin
      if (wr_en && hit(paddr, `SHC_OFF_HANDLER)) begin
        pend_reg <= {pwdata[`SHC_HS_USG_PEND], pwdata[`SHC_HS_BUS_PEND],
                     pwdata[`SHC_HS_MEM_PEND], pwdata[`SHC_HS_SVC_PEND]} | pend_set;
      end else begin
        pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      end
    end
  end
  assign pend_out = pend_reg;

  // active state mirror
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      act_reg <= '0;
    end else if (ce) begin
      act_reg <= active_in;
    end
  end

  // wake sources
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      irq_prev_reg <= '0;
      ext_prev_reg <= 1'b0;
    end else if (ce) begin
      irq_prev_reg <= irq_pending;
      ext_prev_reg <= ext_sync;
    end
  end
  assign irq_new      = irq_pending & ~irq_prev_reg;
  assign irq_wake_src = any_pend_reg ? irq_new : (irq_new & irq_enabled);
  assign any_wake     = (|irq_wake_src) || event_enabled_pulse
                     || send_event_instr || (ext_sync && !ext_prev_reg);

  shc_event_latch u_event (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .event_in  (any_wake && !wfe_waiting_reg && !wait_for_event_instr),
    .consume   (wait_for_event_instr),
    .event_reg (event_reg)
  );

  // wait-for-event tracking
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wfe_waiting_reg <= 1'b0;
      wake_event      <= 1'b0;
      wfe_complete    <= 1'b0;
    end else if (ce) begin
      wake_event   <= any_wake;
      wfe_complete <= 1'b0;
      if (wait_for_event_instr && !wfe_waiting_reg) begin
        if (event_reg || any_wake) begin
          wfe_complete <= 1'b1;
        end else begin
          wfe_waiting_reg <= 1'b1;
        end
      end else if (wfe_waiting_reg && any_wake) begin
        wfe_waiting_reg <= 1'b0;
        wfe_complete    <= 1'b1;
      end
    end
  end

  // power state
  assign doze_req = wait_for_irq_instr || (wait_for_event_instr && !event_reg && !any_wake)
                 || (handler_to_thread && on_exit_reg);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      power_reg <= shc_pkg::SHC_RUN;
    end else if (ce) begin
      case (power_reg)
        shc_pkg::SHC_RUN: begin
          if (doze_req) begin
            power_reg <= deep_reg ? shc_pkg::SHC_DEEP : shc_pkg::SHC_SLEEP;
          end
        end
        shc_pkg::SHC_SLEEP, shc_pkg::SHC_DEEP: begin
          if (any_wake || (|(irq_pending & irq_enabled))) begin
            power_reg <= shc_pkg::SHC_RUN;
          end
        end
        default: begin
          power_reg <= shc_pkg::SHC_RUN;
        end
      endcase
    end
  end
  assign power_state = power_reg;
  assign deep_sleep  = (power_reg == shc_pkg::SHC_DEEP);

  // interrupt status, cleared by read; set wins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      istat_reg <= 2'h0;
    end else if (ce) begin
      // clear only the bits that the setup cycle captured into prdata
      istat_reg <= (istat_reg & ~((rd_en && hit(paddr, `SHC_OFF_IRQ_STATUS))
                                  ? prdata[`SHC_IRQ_BITS-1:0] : 2'h0))
                 | {doze_req && (power_reg == shc_pkg::SHC_RUN), wfe_complete};
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      imask_reg <= 2'h0;
    end else if (wr_en && hit(paddr, `SHC_OFF_IRQ_MASK)) begin
      imask_reg <= pwdata[`SHC_IRQ_BITS-1:0];
    end
  end
  assign irq = |(istat_reg & imask_reg);

  // read mux
  always_comb begin
    rd_word = `SHC_RESET_WORD;
    if (hit(paddr, `SHC_OFF_SLEEP)) begin
      rd_word[`SHC_SLP_ON_EXIT]  = on_exit_reg;
      rd_word[`SHC_SLP_DEEP]     = deep_reg;
      rd_word[`SHC_SLP_ANY_PEND] = any_pend_reg;
    end else if (hit(paddr, `SHC_OFF_HANDLER)) begin
      rd_word[`SHC_HS_USG_EN:`SHC_HS_MEM_EN] = enable_reg;
      rd_word[`SHC_HS_SVC_PEND]  = pend_reg.supervisor;
      rd_word[`SHC_HS_BUS_PEND]  = pend_reg.bus;
      rd_word[`SHC_HS_MEM_PEND]  = pend_reg.memmanage;
      rd_word[`SHC_HS_USG_PEND]  = pend_reg.usage;
      rd_word[`SHC_HS_TICK_ACT]  = act_reg.system_tick;
      rd_word[`SHC_HS_PSV_ACT]   = act_reg.pendable_service;
      rd_word[`SHC_HS_MON_ACT]   = act_reg.debug_monitor;
      rd_word[`SHC_HS_SVC_ACT]   = act_reg.supervisor_call;
      rd_word[`SHC_HS_USG_ACT]   = act_reg.usage_fault;
      rd_word[`SHC_HS_BUS_ACT]   = act_reg.bus_fault;
      rd_word[`SHC_HS_MEM_ACT]   = act_reg.memmanage_fault;
    end else if (hit(paddr, `SHC_OFF_IRQ_STATUS)) begin
      rd_word[`SHC_IRQ_BITS-1:0] = istat_reg;
    end else if (hit(paddr, `SHC_OFF_IRQ_MASK)) begin
      rd_word[`SHC_IRQ_BITS-1:0] = imask_reg;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prdata <= `SHC_RESET_WORD;
    end else if (psel && !penable && !pwrite && ce) begin
      prdata <= rd_word;
    end
  end
endmodule : shc_top

// *** tb/shc_checker.sv ***
// checker for shc_top: register side effects, wake and power outputs
// assumes binding to shc_top, all inputs on mclk
`timescale 1ns/100ps
`include "shc_defs.svh"
module shc_checker #(
  parameter int NUM_IRQ = 8
) (
  input wire logic                   mclk,
  input wire logic                   resetn,
  input wire logic                   ce,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic [NUM_IRQ-1:0]     irq_pending,
  input wire logic [NUM_IRQ-1:0]     irq_enabled,
  input wire logic                   send_event_instr,
  input wire logic                   handler_to_thread,
  input wire shc_pkg::shc_pend_type  pend_set,
  input wire shc_pkg::shc_pend_type  pend_clr,
  input wire shc_pkg::shc_act_type   active_in,
  input wire shc_pkg::shc_pend_type  pend_out,
  input wire logic [2:0]             fault_enable,
  input wire logic                   wake_event,
  input wire shc_pkg::shc_power_type power_state
);
  logic       wr_hs;
  logic       rd_hs;
  logic [2:0] slp_reg;
  assign wr_hs = psel && penable && pwrite && paddr == `SHC_OFF_HANDLER;
  assign rd_hs = psel && !pwrite && paddr == `SHC_OFF_HANDLER;
  // shadow of {any pending, deep, sleep on exit}
  always_ff @(posedge mclk) begin
    if (!resetn) slp_reg <= 3'h0;
    else if (ce && psel && penable && pwrite && paddr == `SHC_OFF_SLEEP)
      slp_reg <= {pwdata[4], pwdata[2:1]};
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !ce);
  a_sev_wakes: assert property (send_event_instr |=> wake_event)
    else $error("no wake after send event");
  a_irq_wakes: assert property (
    |(irq_pending & ~$past(irq_pending) & (irq_enabled | {NUM_IRQ{slp_reg[2]}})) |=> wake_event)
    else $error("no wake after new pending interrupt");
  a_fault_enable: assert property (wr_hs |=> fault_enable == $past(pwdata[18:16]))
    else $error("fault enables differ from write");
  a_pend_write: assert property (wr_hs && pend_set == 4'h0 && pend_clr == 4'h0 |=>
    pend_out == {$past(pwdata[12]), $past(pwdata[14]), $past(pwdata[13]), $past(pwdata[15])})
    else $error("pending bits differ from write");
  a_pend_set: assert property (pend_set != 4'h0 |=>
    (pend_out & $past(pend_set)) == $past(pend_set))
    else $error("pending not set by core");
  a_active_read: assert property (rd_hs && !penable |=>
    {prdata[11:10], prdata[8:7], prdata[3], prdata[1:0]} == $past(active_in, 2))
    else $error("active bits differ");
  a_hs_reserved: assert property (rd_hs && penable |-> (prdata & 32'hFFF8_0274) == 32'h0)
    else $error("reserved handler bits set");
  a_deep_select: assert property (
    $changed(power_state) && power_state != shc_pkg::SHC_RUN |->
    power_state == (slp_reg[1] ? shc_pkg::SHC_DEEP : shc_pkg::SHC_SLEEP))
    else $error("wrong low power mode");
  a_doze_exit: assert property (handler_to_thread && slp_reg[0] |=>
    power_state != shc_pkg::SHC_RUN)
    else $error("no sleep on handler return");
  c_wake: cover property (wake_event);
  c_deep: cover property (power_state == shc_pkg::SHC_DEEP);
  c_hs_write: cover property (wr_hs);
endmodule : shc_checker
bind shc_top shc_checker #(.NUM_IRQ(NUM_IRQ)) i_shc_checker (
  .mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .irq_pending(irq_pending),
  .irq_enabled(irq_enabled), .send_event_instr(send_event_instr),
  .handler_to_thread(handler_to_thread), .pend_set(pend_set), .pend_clr(pend_clr),
  .active_in(active_in), .pend_out(pend_out), .fault_enable(fault_enable),
  .wake_event(wake_event), .power_state(power_state));

// *** tb/shc_core.sv ***
// core-side model: interrupt levels, instruction strobes, fault events
// assumes the bench calls its tasks, mclk domain
`timescale 1ns/100ps
module shc_core (
  input  wire logic             mclk,
  output logic [7:0]            irq_pending,
  output logic [7:0]            irq_enabled,
  output logic [4:0]            strobe,
  output logic                  ext_event_pin,
  output shc_pkg::shc_pend_type pend_set,
  output shc_pkg::shc_pend_type pend_clr,
  output shc_pkg::shc_act_type  active_in
);
  initial begin
    {irq_pending, irq_enabled, strobe, ext_event_pin} = 22'h0;
    {pend_set, pend_clr, active_in} = 15'h0;
  end
  // strobe: event, send event, wait event, wait irq, handler return
  task automatic fire(input logic [4:0] s);
    @(posedge mclk);
    strobe <= s;
    @(posedge mclk);
    strobe <= 5'h00;
  endtask : fire
  // pending level held three cycles, then withdrawn
  task automatic irq(input logic [7:0] p, input logic [7:0] e);
    @(posedge mclk);
    irq_pending <= p;
    irq_enabled <= e;
    repeat (3) @(posedge mclk);
    irq_pending <= 8'h00;
  endtask : irq
  task automatic ext();
    @(posedge mclk);
    ext_event_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    ext_event_pin <= 1'b0;
  endtask : ext
  task automatic fault(input shc_pkg::shc_pend_type s, input shc_pkg::shc_pend_type c);
    @(posedge mclk);
    pend_set <= s;
    pend_clr <= c;
    @(posedge mclk);
    pend_set <= 4'h0;
    pend_clr <= 4'h0;
  endtask : fault
  task automatic act(input shc_pkg::shc_act_type v);
    @(posedge mclk);
    active_in <= v;
  endtask : act
endmodule : shc_core

// *** tb/tb_top.sv ***
// bench for shc_top: apb register access, wake and power paths
// assumes shc_core drives every core-side input
`timescale 1ns/100ps
`include "shc_defs.svh"
module tb_top;
  logic mclk, resetn, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] irq_pending, irq_enabled;
  logic [4:0] strobe;
  logic [2:0] fault_enable;
  logic ext_event_pin, wake_event, wfe_complete, deep_sleep, irq;
  shc_pkg::shc_pend_type pend_set, pend_clr, pend_out;
  shc_pkg::shc_act_type active_in;
  shc_pkg::shc_power_type power_state;
  int n_errors, checks, wakes, dones, cyc;
  shc_top #(.NUM_IRQ(8)) i_shc_top (
    .mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pending(irq_pending), .irq_enabled(irq_enabled),
    .event_enabled_pulse(strobe[0]), .send_event_instr(strobe[1]),
    .ext_event_pin(ext_event_pin), .wait_for_event_instr(strobe[2]),
    .wait_for_irq_instr(strobe[3]), .handler_to_thread(strobe[4]), .pend_set(pend_set),
    .pend_clr(pend_clr), .active_in(active_in), .pend_out(pend_out),
    .fault_enable(fault_enable), .wake_event(wake_event), .wfe_complete(wfe_complete),
    .power_state(power_state), .deep_sleep(deep_sleep), .irq(irq));
  shc_core i_shc_core (
    .mclk(mclk), .irq_pending(irq_pending), .irq_enabled(irq_enabled), .strobe(strobe),
    .ext_event_pin(ext_event_pin), .pend_set(pend_set), .pend_clr(pend_clr),
    .active_in(active_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    wakes += int'(wake_event === 1'b1);
    dones += int'(wfe_complete === 1'b1);
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(nm, rd, exp);
  endtask : rdchk
  task automatic pwr(input shc_pkg::shc_power_type exp);
    repeat (3) @(posedge mclk);
    check("power state", 32'(power_state), 32'(exp));
  endtask : pwr
  initial begin
    {n_errors, checks, wakes, dones, cyc} = '0;
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk("reset word", 12'(4 * i), 32'h0);
    apb(`SHC_OFF_SLEEP, 1'b1, 32'hFFFF_FFFF);
    rdchk("sleep word", `SHC_OFF_SLEEP, 32'h0000_0016);
    apb(`SHC_OFF_HANDLER, 1'b1, 32'hFFFF_FFFF);
    rdchk("handler word", `SHC_OFF_HANDLER, 32'h0007_F000);
    check("fault enables", {29'h0, fault_enable}, 32'h7);
    apb(`SHC_OFF_HANDLER, 1'b1, 32'h0);
    rdchk("handler cleared", `SHC_OFF_HANDLER, 32'h0);
    apb(12'h010, 1'b1, 32'hFFFF_FFFF);
    rdchk("unmapped", 12'h010, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    for (int i = 0; i < 2; i++) begin
      i_shc_core.act(i ? 7'h2A : 7'h55);
      rdchk("active bits", `SHC_OFF_HANDLER, i ? 32'h482 : 32'h909);
      i_shc_core.fault(i ? 4'h5 : 4'hA, 4'h0);
      rdchk("pending set", `SHC_OFF_HANDLER, i ? 32'hC482 : 32'h3909);
      i_shc_core.fault(4'h0, i ? 4'h5 : 4'hA);
    end
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h0);
    apb(`SHC_OFF_IRQ_MASK, 1'b1, 32'h3);
    wakes = 0;
    i_shc_core.irq(8'h01, 8'h00);
    i_shc_core.irq(8'h02, 8'h02);
    repeat (3) @(posedge mclk);
    check("enabled wakes", 32'(wakes), 32'h1);
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h10);
    wakes = 0;
    i_shc_core.irq(8'h04, 8'h00);
    i_shc_core.fire(5'h02);
    i_shc_core.fire(5'h01);
    i_shc_core.ext();
    repeat (6) @(posedge mclk);
    check("any pending wakes", 32'(wakes), 32'h4);
    dones = 0;
    i_shc_core.fire(5'h04);
    pwr(shc_pkg::SHC_RUN);
    check("wait completes", 32'(dones), 32'h1);
    i_shc_core.fire(5'h04);
    pwr(shc_pkg::SHC_SLEEP);
    apb(`SHC_OFF_IRQ_MASK, 1'b1, 32'h0);
    @(negedge mclk);
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(`SHC_OFF_IRQ_MASK, 1'b1, 32'h3);
    @(negedge mclk);
    check("unmasked irq", {31'h0, irq}, 32'h1);
    rdchk("irq status", `SHC_OFF_IRQ_STATUS, 32'h3);
    @(negedge mclk);
    check("cleared irq", {31'h0, irq}, 32'h0);
    i_shc_core.fire(5'h02);
    pwr(shc_pkg::SHC_RUN);
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h4);
    i_shc_core.fire(5'h08);
    pwr(shc_pkg::SHC_DEEP);
    check("deep flag", {31'h0, deep_sleep}, 32'h1);
    i_shc_core.irq(8'h08, 8'h08);
    pwr(shc_pkg::SHC_RUN);
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h2);
    i_shc_core.fire(5'h10);
    pwr(shc_pkg::SHC_SLEEP);
    i_shc_core.irq(8'h10, 8'h10);
    pwr(shc_pkg::SHC_RUN);
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h0);
    i_shc_core.fire(5'h10);
    pwr(shc_pkg::SHC_RUN);
    // clock enable low: neither a write nor a wake source may change state
    ce <= 1'b0;
    wakes = 0;
    apb(`SHC_OFF_SLEEP, 1'b1, 32'h4);
    i_shc_core.fire(5'h02);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    check("frozen wakes", 32'(wakes), 32'h0);
    rdchk("frozen sleep", `SHC_OFF_SLEEP, 32'h0);
    conclude();
  end
endmodule : tb_top
